/* File: core/cgu_pkg.sv */
// constants, types and decode helpers for the integer compare unit
// Contract
// - opcode 0010 is signed greater-or-equal
// - opcode 0011 unsigned greater-or-equal, immediate zero-extended
// - opcode 0100 is signed strictly greater
// - opcode 0101 is unsigned strictly greater
// - opcode 0110 is signed less-or-equal
// - register form: dest 17:12, sources 11:6, 5:0
// - bit 25 sends one bit to branch register
// - bit 27: immediate 20:12, dest 11:6
// - immediate branch form: branch dest at 8:6
// - no placement or alignment fault for these
// - back-to-back dependent operations give correct results
package cgu_pkg;
    localparam int DATA_W    = 32;
    localparam int GPR_AW    = 6;
    localparam int GPR_DEPTH = 64;
    localparam int BR_AW     = 3;
    localparam int BR_COUNT  = 8;
    localparam int IMM_W     = 9;
    localparam int STOP_BIT  = 31;
    localparam int FMT_HI    = 29;
    localparam int FMT_LO    = 28;
    localparam int IMM_BIT   = 27;
    localparam int CLASS_BIT = 26;
    localparam int BR_BIT    = 25;
    localparam int OPC_HI    = 24;
    localparam int OPC_LO    = 21;
    localparam int BDST_HI   = 20;
    localparam int BDST_LO   = 18;
    localparam int DST_HI    = 17;
    localparam int DST_LO    = 12;
    localparam int IMM_HI    = 20;
    localparam int IMM_LO    = 12;
    localparam int SECOND_SOURCE_INDEX_HI   = 11;
    localparam int SECOND_SOURCE_INDEX_LO   = 6;
    localparam int IDST_HI   = 11;
    localparam int IDST_LO   = 6;
    localparam int IBDST_HI  = 8;
    localparam int IBDST_LO  = 6;
    localparam int FIRST_SOURCE_INDEX_HI   = 5;
    localparam int FIRST_SOURCE_INDEX_LO   = 0;
    localparam logic [1:0] FMT_CMP = 2'h0;
    localparam logic [3:0] OPC_GE  = 4'h2;
    localparam logic [3:0] OPC_GEU = 4'h3;
    localparam logic [3:0] OPC_GT  = 4'h4;
    localparam logic [3:0] OPC_GTU = 4'h5;
    localparam logic [3:0] OPC_LE  = 4'h6;
    localparam logic [DATA_W-1:0] WORD_TRUE  = 32'h0000_0001;
    localparam logic [DATA_W-1:0] WORD_FALSE = 32'h0000_0000;

    typedef enum logic [2:0] {
        CMP_NONE,
        CMP_GE,
        CMP_GEU,
        CMP_GT,
        CMP_GTU,
        CMP_LE
    } cgu_cmp_t;

    function automatic cgu_cmp_t cgu_kind_of(input logic [31:0] word);
        cgu_cmp_t k;
        k = CMP_NONE;
        if (word[FMT_HI:FMT_LO] == FMT_CMP && word[CLASS_BIT]) begin
            case (word[OPC_HI:OPC_LO])
                OPC_GE:  k = CMP_GE;
                OPC_GEU: k = CMP_GEU;
                OPC_GT:  k = CMP_GT;
                OPC_GTU: k = CMP_GTU;
                OPC_LE:  k = CMP_LE;
                default: k = CMP_NONE;
            endcase
        end
        return k;
    endfunction

    function automatic logic cgu_is_signed(input cgu_cmp_t k);
        return (k == CMP_GE) || (k == CMP_GT) || (k == CMP_LE);
    endfunction
endpackage

/* File: core/cgu_rf_if.sv */
// general register file port bundle between compare unit and its store
`timescale 1ns/1ps
interface cgu_rf_if #(
    parameter int AW = 6,
    parameter int DW = 32
);
    logic [AW-1:0] rd_addr_a;
    logic [AW-1:0] rd_addr_b;
    logic [DW-1:0] rd_data_a;
    logic [DW-1:0] rd_data_b;
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;

    modport user (
        output rd_addr_a,
        output rd_addr_b,
        output we,
        output waddr,
        output wdata,
        input  rd_data_a,
        input  rd_data_b
    );
    modport store (
        input  rd_addr_a,
        input  rd_addr_b,
        input  we,
        input  waddr,
        input  wdata,
        output rd_data_a,
        output rd_data_b
    );
endinterface

/* File: core/cgu_gpr_mem.sv */
// general register file: two registered read ports, one write-first write port
`timescale 1ns/1ps
module cgu_gpr_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 32
) (
    input wire logic clk_sys,
    input wire logic nrst,
    cgu_rf_if.store  rf
);
    logic [DW-1:0] mem [DEPTH];
    logic          hit_a;
    logic          hit_b;

    // same-edge write is forwarded so a dependent read never sees stale data
    assign hit_a = rf.we && (rf.waddr == rf.rd_addr_a);
    assign hit_b = rf.we && (rf.waddr == rf.rd_addr_b);

    always_ff @(posedge clk_sys) begin
        if (rf.we) begin
            mem[rf.waddr] <= rf.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rf.rd_data_a <= '0;
            rf.rd_data_b <= '0;
        end else begin
            rf.rd_data_a <= hit_a ? rf.wdata : mem[rf.rd_addr_a];
            rf.rd_data_b <= hit_b ? rf.wdata : mem[rf.rd_addr_b];
        end
    end
endmodule

/* File: core/cgu_compare_unit.sv */
// compare execution unit: decode, operand fetch, compare, register writeback
`timescale 1ns/1ps
module cgu_compare_unit #(
    parameter int GPR_DEPTH = cgu_pkg::GPR_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        issue_valid,
    input  wire logic [31:0] issue_word,
    input  wire logic        load_we,
    input  wire logic [5:0]  load_addr,
    input  wire logic [31:0] load_data,
    output logic             load_ready,
    output logic             issue_ignored,
    output logic             res_valid,
    output logic             res_gpr_we,
    output logic [5:0]       res_gpr_addr,
    output logic [31:0]      res_gpr_data,
    output logic             res_br_we,
    output logic [2:0]       res_br_addr,
    output logic             res_br_bit,
    output logic [7:0]       br_file,
    output logic             res_stop
);
    cgu_rf_if #(.AW(cgu_pkg::GPR_AW), .DW(cgu_pkg::DATA_W)) rf ();

    cgu_gpr_mem #(
        .DEPTH (GPR_DEPTH),
        .AW    (cgu_pkg::GPR_AW),
        .DW    (cgu_pkg::DATA_W)
    ) u_gpr (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .rf      (rf.store)
    );

    // issue-side decode
    cgu_pkg::cgu_cmp_t              issue_kind;
    logic                           issue_hit;
    logic                           issue_imm;
    logic                           issue_br;
    logic [cgu_pkg::GPR_AW-1:0]     issue_gdst;
    logic [cgu_pkg::BR_AW-1:0]      issue_bdst;

    assign issue_kind    = cgu_pkg::cgu_kind_of(issue_word);
    assign issue_hit     = issue_valid && (issue_kind != cgu_pkg::CMP_NONE);
    // no slot or address check: any syllable position is accepted
    assign issue_ignored = issue_valid && !issue_hit;
    assign issue_imm     = issue_word[cgu_pkg::IMM_BIT];
    assign issue_br      = issue_word[cgu_pkg::BR_BIT];
    assign issue_gdst    = issue_imm ? issue_word[cgu_pkg::IDST_HI:cgu_pkg::IDST_LO]
                                     : issue_word[cgu_pkg::DST_HI:cgu_pkg::DST_LO];
    assign issue_bdst    = issue_imm ? issue_word[cgu_pkg::IBDST_HI:cgu_pkg::IBDST_LO]
                                     : issue_word[cgu_pkg::BDST_HI:cgu_pkg::BDST_LO];
    assign rf.rd_addr_a  = issue_word[cgu_pkg::FIRST_SOURCE_INDEX_HI:cgu_pkg::FIRST_SOURCE_INDEX_LO];
    assign rf.rd_addr_b  = issue_word[cgu_pkg::SECOND_SOURCE_INDEX_HI:cgu_pkg::SECOND_SOURCE_INDEX_LO];

    // execute stage, aligned with the registered read data
    logic                           s1_valid_reg;
    cgu_pkg::cgu_cmp_t              s1_kind_reg;
    logic                           s1_imm_reg;
    logic                           s1_br_reg;
    logic [cgu_pkg::GPR_AW-1:0]     s1_gdst_reg;
    logic [cgu_pkg::BR_AW-1:0]      s1_bdst_reg;
    logic [cgu_pkg::IMM_W-1:0]      s1_imm_val_reg;
    logic                           s1_stop_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_valid_reg   <= 1'b0;
            s1_kind_reg    <= cgu_pkg::CMP_NONE;
            s1_imm_reg     <= 1'b0;
            s1_br_reg      <= 1'b0;
            s1_gdst_reg    <= '0;
            s1_bdst_reg    <= '0;
            s1_imm_val_reg <= '0;
            s1_stop_reg    <= 1'b0;
        end else begin
            s1_valid_reg   <= issue_hit;
            s1_kind_reg    <= issue_kind;
            s1_imm_reg     <= issue_imm;
            s1_br_reg      <= issue_br;
            s1_gdst_reg    <= issue_gdst;
            s1_bdst_reg    <= issue_bdst;
            s1_imm_val_reg <= issue_word[cgu_pkg::IMM_HI:cgu_pkg::IMM_LO];
            s1_stop_reg    <= issue_word[cgu_pkg::STOP_BIT];
        end
    end

    logic                           s1_signed;
    logic [cgu_pkg::DATA_W-1:0]     imm_ext;
    logic [cgu_pkg::DATA_W-1:0]     op_a;
    logic [cgu_pkg::DATA_W-1:0]     op_b;
    logic                           gt_s;
    logic                           gt_u;
    logic                           eq_ab;
    logic                           cmp_true;
    logic                           cmp_gpr_we;

    assign s1_signed = cgu_pkg::cgu_is_signed(s1_kind_reg);
    // unsigned forms zero-extend the short immediate
    assign imm_ext   = s1_signed ? {{23{s1_imm_val_reg[8]}}, s1_imm_val_reg}
                                 : {23'h0, s1_imm_val_reg};
    assign op_a      = rf.rd_data_a;
    assign op_b      = s1_imm_reg ? imm_ext : rf.rd_data_b;
    assign gt_s      = $signed(op_a) > $signed(op_b);
    assign gt_u      = op_a > op_b;
    assign eq_ab     = op_a == op_b;

    always_comb begin
        case (s1_kind_reg)
            cgu_pkg::CMP_GE:  cmp_true = gt_s || eq_ab;
            cgu_pkg::CMP_GEU: cmp_true = gt_u || eq_ab;
            cgu_pkg::CMP_GT:  cmp_true = gt_s;
            cgu_pkg::CMP_GTU: cmp_true = gt_u;
            cgu_pkg::CMP_LE:  cmp_true = !gt_s;
            default:          cmp_true = 1'b0;
        endcase
    end

    // compare writeback owns the write port; a load in that cycle is dropped while load_ready is low
    assign cmp_gpr_we = s1_valid_reg && !s1_br_reg;
    assign load_ready = !cmp_gpr_we;
    assign rf.we      = cmp_gpr_we || load_we;
    assign rf.waddr   = cmp_gpr_we ? s1_gdst_reg : load_addr;
    assign rf.wdata   = cmp_gpr_we ? (cmp_true ? cgu_pkg::WORD_TRUE : cgu_pkg::WORD_FALSE)
                                   : load_data;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            res_valid    <= 1'b0;
            res_gpr_we   <= 1'b0;
            res_gpr_addr <= '0;
            res_gpr_data <= '0;
            res_br_we    <= 1'b0;
            res_br_addr  <= '0;
            res_br_bit   <= 1'b0;
            res_stop     <= 1'b0;
        end else begin
            res_valid    <= s1_valid_reg;
            res_gpr_we   <= cmp_gpr_we;
            res_gpr_addr <= s1_gdst_reg;
            res_gpr_data <= cmp_true ? cgu_pkg::WORD_TRUE : cgu_pkg::WORD_FALSE;
            res_br_we    <= s1_valid_reg && s1_br_reg;
            res_br_addr  <= s1_bdst_reg;
            res_br_bit   <= cmp_true;
            res_stop     <= s1_stop_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            br_file <= '0;
        end else if (s1_valid_reg && s1_br_reg) begin
            br_file[s1_bdst_reg] <= cmp_true;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence issue_rr_gpr_s;
        issue_hit && !issue_imm && !issue_br;
    endsequence
    sequence issue_rr_br_s;
        issue_hit && !issue_imm && issue_br;
    endsequence
    sequence issue_imm_gpr_s;
        issue_hit && issue_imm && !issue_br;
    endsequence
    sequence issue_imm_br_s;
        issue_hit && issue_imm && issue_br;
    endsequence

    signed_ge_a: assert property (s1_valid_reg && s1_kind_reg == cgu_pkg::CMP_GE |=>
        res_br_bit == ($signed($past(op_a)) >= $signed($past(op_b))))
        else $error("signed ge result wrong");
    unsigned_ge_a: assert property (s1_valid_reg && s1_kind_reg == cgu_pkg::CMP_GEU |=>
        res_br_bit == ($past(op_a) >= $past(op_b)))
        else $error("unsigned ge result wrong");
    signed_gt_a: assert property (s1_valid_reg && s1_kind_reg == cgu_pkg::CMP_GT |=>
        res_br_bit == ($signed($past(op_a)) > $signed($past(op_b))))
        else $error("signed gt result wrong");
    unsigned_gt_a: assert property (s1_valid_reg && s1_kind_reg == cgu_pkg::CMP_GTU |=>
        res_br_bit == ($past(op_a) > $past(op_b)))
        else $error("unsigned gt result wrong");
    signed_le_a: assert property (s1_valid_reg && s1_kind_reg == cgu_pkg::CMP_LE |=>
        res_br_bit == ($signed($past(op_a)) <= $signed($past(op_b))))
        else $error("signed le result wrong");
    rr_gpr_dest_a: assert property (issue_rr_gpr_s |-> ##2 res_gpr_we && !res_br_we
        && res_gpr_addr == $past(issue_word[17:12], 2))
        else $error("register form destination wrong");
    rr_br_dest_a: assert property (issue_rr_br_s |-> ##2 res_br_we && !res_gpr_we
        && res_br_addr == $past(issue_word[20:18], 2))
        else $error("branch destination wrong");
    imm_gpr_dest_a: assert property (issue_imm_gpr_s |-> ##2 res_gpr_we
        && res_gpr_addr == $past(issue_word[11:6], 2))
        else $error("immediate form destination wrong");
    imm_br_dest_a: assert property (issue_imm_br_s |-> ##2 res_br_we
        && res_br_addr == $past(issue_word[8:6], 2) && br_file[res_br_addr] == res_br_bit)
        else $error("immediate branch destination wrong");
    any_slot_a: assert property (issue_hit |-> !issue_ignored ##2 res_valid)
        else $error("compare not executed");
    fwd_read_a: assert property (rf.we && rf.waddr == rf.rd_addr_a |=>
        rf.rd_data_a == $past(rf.wdata))
        else $error("dependent read saw stale value");
    gpr_word_a: assert property (res_gpr_we |-> res_gpr_data == {31'h0, res_br_bit}
        && u_gpr.mem[res_gpr_addr] == res_gpr_data)
        else $error("general result not one or zero");
    stop_pass_a: assert property (issue_hit |-> ##2 res_stop == $past(issue_word[31], 2))
        else $error("stop marker not carried");
endmodule

/* File: test/cgu_compare_unit_test.sv */
// self-checking bench for the integer compare unit
`timescale 1ns/1ps
module cgu_compare_unit_test;
    typedef struct packed {
        logic        gw;
        logic [5:0]  ga;
        logic [31:0] gd;
        logic        bw;
        logic [2:0]  ba;
        logic        bb;
        logic        st;
    } cgu_obs_t;

    logic        clk_sys;
    logic        nrst;
    logic        issue_valid;
    logic [31:0] issue_word;
    logic        load_we;
    logic [5:0]  load_addr;
    logic [31:0] load_data;
    logic        load_ready;
    logic        issue_ignored;
    logic        res_valid;
    logic        res_gpr_we;
    logic [5:0]  res_gpr_addr;
    logic [31:0] res_gpr_data;
    logic        res_br_we;
    logic [2:0]  res_br_addr;
    logic        res_br_bit;
    logic [7:0]  br_file;
    logic        res_stop;
    cgu_obs_t    obs_q[$];
    int          n_fail;
    int          num_checks;
    // signed and unsigned orderings disagree on two of the five neighbouring pairs
    logic [31:0] a_tab[5] = '{32'h0000_01ff, 32'hffff_ffff, 32'h8000_0000, 32'h5, 32'h5};
    logic [8:0]  i_tab[5] = '{9'h1ff, 9'h1ff, 9'h100, 9'h005, 9'h006};

    cgu_compare_unit dut (
        .clk_sys(clk_sys), .nrst(nrst), .issue_valid(issue_valid), .issue_word(issue_word),
        .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
        .load_ready(load_ready), .issue_ignored(issue_ignored), .res_valid(res_valid),
        .res_gpr_we(res_gpr_we), .res_gpr_addr(res_gpr_addr), .res_gpr_data(res_gpr_data),
        .res_br_we(res_br_we), .res_br_addr(res_br_addr), .res_br_bit(res_br_bit),
        .br_file(br_file), .res_stop(res_stop)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // sampled before the edge's own updates, so a two-cycle pulse shows as two entries
    always @(posedge clk_sys) begin
        if (res_valid === 1'b1) begin
            obs_q.push_back({res_gpr_we, res_gpr_addr, res_gpr_data, res_br_we, res_br_addr,
                             res_br_bit, res_stop});
        end
    end

    function automatic logic [31:0] enc(input logic st, input logic im, input logic br,
                                        input logic [3:0] opc, input logic [8:0] f1,
                                        input logic [5:0] f2, input logic [5:0] s1);
        return {st, 1'b0, 2'b00, im, 1'b1, br, opc, f1, f2, s1};
    endfunction

    function automatic logic ref_cmp(input logic [3:0] opc, input logic [31:0] a,
                                     input logic [31:0] b);
        case (opc)
            cgu_pkg::OPC_GE:  return $signed(a) >= $signed(b);
            cgu_pkg::OPC_GEU: return a >= b;
            cgu_pkg::OPC_GT:  return $signed(a) > $signed(b);
            cgu_pkg::OPC_GTU: return a > b;
            default:          return $signed(a) <= $signed(b);
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic drive(input logic v, input logic [31:0] w);
        @(posedge clk_sys);
        issue_valid <= v;
        issue_word  <= w;
    endtask

    task automatic load(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        load_we   <= 1'b1;
        load_addr <= a;
        load_data <= d;
    endtask

    task automatic load_end;
        @(posedge clk_sys);
        load_we <= 1'b0;
    endtask

    task automatic get(output cgu_obs_t r);
        for (int n = 0; n < 6 && obs_q.size() == 0; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (obs_q.size() == 0) begin
            n_fail++;
            $display("Error result expected 1 seen 0");
            tally_and_finish();
        end else begin
            r = obs_q.pop_front();
        end
    endtask

    task automatic check_obs(input logic [31:0] w, input logic exp, input logic [5:0] dst);
        cgu_obs_t r;
        get(r);
        check("stop", 32'(r.st), 32'(w[31]));
        check("gpr_we", 32'(r.gw), 32'(!w[25]));
        check("br_we", 32'(r.bw), 32'(w[25]));
        check("outcome", 32'(r.bb), 32'(exp));
        if (!w[25]) begin
            check("gpr_addr", 32'(r.ga), 32'(dst));
            check("gpr_data", r.gd, {31'h0, exp});
        end else begin
            check("br_addr", 32'(r.ba), 32'(dst));
            check("br_file", 32'(br_file[dst[2:0]]), 32'(exp));
        end
    endtask

    task automatic run_op(input logic [31:0] w, input logic exp, input logic [5:0] dst);
        drive(1'b1, w);
        #1;
        check("issue_ignored", 32'(issue_ignored), 32'h0);
        drive(1'b0, 32'h0);
        #1;
        check("load_ready", 32'(load_ready), 32'(w[25]));
        check_obs(w, exp, dst);
    endtask

    // every opcode in all four forms, stop marker toggled across the table
    task automatic t_forms;
        logic [3:0]  opc;
        logic [31:0] b;
        logic [31:0] bi;
        logic [2:0]  bd;
        for (int p = 0; p < 5; p++) begin
            load(6'(10 + p), a_tab[p]);
            load(6'(40 + p), a_tab[(p + 1) % 5]);
        end
        load_end();
        for (int i = 0; i < 5; i++) begin
            opc = 4'(2 + i);
            for (int p = 0; p < 5; p++) begin
                bd = 3'(i + p);
                b  = a_tab[(p + 1) % 5];
                bi = (opc == cgu_pkg::OPC_GEU || opc == cgu_pkg::OPC_GTU) ?
                     {23'h0, i_tab[p]} : {{23{i_tab[p][8]}}, i_tab[p]};
                run_op(enc(p[0], 1'b0, 1'b0, opc, {3'h0, 6'(63 - p)}, 6'(40 + p), 6'(10 + p)),
                       ref_cmp(opc, a_tab[p], b), 6'(63 - p));
                run_op(enc(!p[0], 1'b0, 1'b1, opc, {bd, 6'h0}, 6'(40 + p), 6'(10 + p)),
                       ref_cmp(opc, a_tab[p], b), {3'h0, bd});
                run_op(enc(p[0], 1'b1, 1'b0, opc, i_tab[p], 6'(20 + p), 6'(10 + p)),
                       ref_cmp(opc, a_tab[p], bi), 6'(20 + p));
                run_op(enc(!p[0], 1'b1, 1'b1, opc, i_tab[p], {3'h0, ~bd}, 6'(10 + p)),
                       ref_cmp(opc, a_tab[p], bi), {3'h0, ~bd});
            end
        end
    endtask

    // each operation after the first reads the result of the one issued just before it
    task automatic t_chain;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        w0 = enc(1'b0, 1'b0, 1'b0, cgu_pkg::OPC_GT, {3'h0, 6'd32}, 6'd31, 6'd30);
        w1 = enc(1'b1, 1'b1, 1'b0, cgu_pkg::OPC_GE, 9'h001, 6'd33, 6'd32);
        w2 = enc(1'b0, 1'b1, 1'b1, cgu_pkg::OPC_LE, 9'h000, 6'h05, 6'd33);
        load(6'd30, 32'd20);
        load(6'd31, 32'd10);
        load_end();
        drive(1'b1, w0);
        drive(1'b1, w1);
        drive(1'b1, w2);
        drive(1'b0, 32'h0);
        check_obs(w0, 1'b1, 6'd32);
        check_obs(w1, 1'b1, 6'd33);
        check_obs(w2, 1'b0, 6'd5);
    endtask

    // neighbouring compares and malformed words must leave no trace
    task automatic t_refused;
        logic [7:0]  br_seen;
        logic [31:0] w[5] = '{enc(1'b0, 1'b0, 1'b0, 4'h0, 9'h0, 6'h1, 6'h2),
                              enc(1'b0, 1'b1, 1'b1, 4'h7, 9'h0, 6'h1, 6'h2),
                              enc(1'b1, 1'b0, 1'b1, 4'h8, 9'h0, 6'h1, 6'h2),
                              enc(1'b0, 1'b0, 1'b1, 4'h2, 9'h0, 6'h1, 6'h2) | 32'h1000_0000,
                              enc(1'b0, 1'b0, 1'b1, 4'h4, 9'h0, 6'h1, 6'h2) & 32'hfbff_ffff};
        br_seen = br_file;
        foreach (w[k]) begin
            drive(1'b1, w[k]);
            #1;
            check("issue_ignored", 32'(issue_ignored), 32'h1);
        end
        // a group word with valid low must not execute
        drive(1'b0, enc(1'b0, 1'b0, 1'b1, cgu_pkg::OPC_GE, 9'h0, 6'h1, 6'h2));
        #1;
        check("issue_ignored", 32'(issue_ignored), 32'h0);
        drive(1'b0, 32'h0);
        repeat (3) @(posedge clk_sys);
        #1;
        check("stray results", 32'(obs_q.size()), 32'h0);
        check("br_file kept", 32'(br_file), 32'(br_seen));
    endtask

    initial begin
        n_fail      = 0;
        num_checks  = 0;
        nrst        = 1'b0;
        issue_valid = 1'b0;
        issue_word  = 32'h0;
        load_we     = 1'b0;
        load_addr   = 6'h0;
        load_data   = 32'h0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        check("br_file reset", 32'(br_file), 32'h0);
        check("res_valid reset", 32'(res_valid), 32'h0);
        t_forms();
        t_chain();
        t_refused();
        check("leftover results", 32'(obs_q.size()), 32'h0);
        tally_and_finish();
    end
endmodule
